// ===== shared/mawe_pkg.sv
// constants shared by the selective-repeat window engine
// ==========================================================
// Summary of operation
// - expected id with data is delivered; expected id without data is dropped
// - an in-window id ahead of expected marks the skipped ids as lost
// - out-of-order data is held until all earlier ids are delivered
// - ids outside the receive window are ignored as late retransmissions
// - with nacks, everything below the first nack retires from the send window
// - with only an ack, everything before the acked id retires
// - every nacked packet is queued for resend as soon as possible
// - flush bit set on full window, convergence layer request, or flush timeout
// - an incoming packet with flush set always produces an acknowledgement
// - acknowledgements advertise the free receive window
// - optional unsolicited ack after a set interval since the last ack
// - sender progress never depends on unsolicited acks
// - each unacknowledged packet has its own resend timer
// - timer resends and nack resends do not disturb one another
// - too many timeout retries on one packet tears the connection down
// - timeouts and the retry limit are parameters
package mawe_pkg;
	localparam int ID_W = 6;
	localparam int WIN_LOG = 3;
	localparam int DATA_W = 32;
	localparam int CLK_PERIOD_NS = 5;
	// timers advance on a coarse tick to keep per-entry counters narrow
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 8;
	localparam int RETX_TICKS = 50;
	localparam int FLUSH_TICKS = 20;
	localparam int ACK_GAP_TICKS = 40;
	localparam int MAX_RETRIES = 3;
	localparam int RETRY_W = 4;
endpackage : mawe_pkg

// ===== rtl/mawe_engine.sv
// selective-repeat window engine: receive reorder, send window, timers
`timescale 1ns/1ps
module mawe_engine #(
	parameter int ID_W = mawe_pkg::ID_W,
	parameter int WIN_LOG = mawe_pkg::WIN_LOG,
	parameter int DATA_W = mawe_pkg::DATA_W,
	parameter int TICK_CYC = mawe_pkg::TICK_CYC,
	parameter int RETX_TICKS = mawe_pkg::RETX_TICKS,
	parameter int FLUSH_TICKS = mawe_pkg::FLUSH_TICKS,
	parameter int ACK_GAP_TICKS = mawe_pkg::ACK_GAP_TICKS,
	parameter int MAX_RETRIES = mawe_pkg::MAX_RETRIES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic rx_valid,
	input wire logic [ID_W-1:0] rx_packet_sequence_id,
	input wire logic rx_has_data,
	input wire logic rx_flush,
	input wire logic [DATA_W-1:0] rx_data,
	output logic convergence_layer_valid,
	output logic [DATA_W-1:0] convergence_layer_data,
	input wire logic convergence_layer_ready,
	input wire logic ack_auto_en,
	output logic ack_valid,
	output logic [ID_W-1:0] ack_packet_sequence_id,
	output logic ack_nack_present,
	output logic [WIN_LOG:0] ack_window,
	input wire logic ack_ready,
	input wire logic tx_new_valid,
	output logic tx_new_ready,
	input wire logic convergence_layer_flush_req,
	output logic snd_valid,
	output logic [ID_W-1:0] snd_packet_sequence_id,
	output logic snd_retx,
	output logic snd_flush,
	input wire logic snd_ready,
	input wire logic fb_valid,
	input wire logic fb_nack_present,
	input wire logic [ID_W-1:0] fb_nack_id,
	input wire logic fb_ack_present,
	input wire logic [ID_W-1:0] fb_ack_id,
	input wire logic [WIN_LOG:0] fb_window,
	input wire logic nack_valid,
	input wire logic [ID_W-1:0] nack_id,
	output logic teardown
);
	import mawe_pkg::*;

	localparam int WIN = 1 << WIN_LOG;
	localparam logic [WIN_LOG:0] WIN_FULL = (WIN_LOG+1)'(WIN);
	localparam logic [TICK_W-1:0] RETX_LOAD = TICK_W'(RETX_TICKS);
	localparam logic [TICK_W-1:0] FLUSH_LOAD = TICK_W'(FLUSH_TICKS);
	localparam logic [TICK_W-1:0] ACK_LOAD = TICK_W'(ACK_GAP_TICKS);
	localparam logic [RETRY_W-1:0] RETRY_MAX = RETRY_W'(MAX_RETRIES);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

	// ==========================================================
	// tick divider
	logic [15:0] div;
	logic tick;
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			div <= 16'h0000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (div == TICK_LAST);
			div <= (div == TICK_LAST) ? 16'h0000 : div + 16'h0001;
		end

	// ==========================================================
	// receive window and reorder store
	logic [ID_W-1:0] rx_exp;
	logic [ID_W-1:0] rx_top;
	logic [DATA_W-1:0] rbuf_data [WIN];
	logic [WIN-1:0] rbuf_ok;
	logic [ID_W-1:0] rx_off;
	logic [ID_W-1:0] top_off;
	logic rx_in_win;
	logic [WIN_LOG-1:0] rx_slot;
	logic [WIN_LOG-1:0] exp_slot;
	logic deliver;
	logic sp_valid;
	logic [DATA_W-1:0] sp_data;

	assign rx_off = rx_packet_sequence_id - rx_exp;
	assign top_off = rx_top - rx_exp;
	assign rx_in_win = rx_off < ID_W'(WIN);
	assign rx_slot = rx_packet_sequence_id[WIN_LOG-1:0];
	assign exp_slot = rx_exp[WIN_LOG-1:0];
	// only hand over while the spare slot is free, so a stall loses nothing
	assign deliver = rbuf_ok[exp_slot] && !sp_valid;

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			rx_exp <= '0;
			rx_top <= '0;
		end
		else
		begin
			if (deliver)
				rx_exp <= rx_exp + 1'b1;
			// a no-data expected id must not skip a word still waiting for the spare slot
			else if (rx_valid && rx_in_win && rx_off == '0 && !rx_has_data
				&& !rbuf_ok[exp_slot])
				rx_exp <= rx_exp + 1'b1;
			// highest id seen bounds the gap reported as lost
			if (rx_valid && rx_in_win && (rx_off + 1'b1) > top_off)
				rx_top <= rx_packet_sequence_id + 1'b1;
			else if (top_off > ID_W'(WIN))
				rx_top <= rx_exp;
		end

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			rbuf_ok <= '0;
		else
			for (int i = 0; i < WIN; i++)
				if (rx_valid && rx_in_win && rx_has_data && rx_slot == WIN_LOG'(i)
					&& !rbuf_ok[i])
					rbuf_ok[i] <= 1'b1;
				else if (deliver && exp_slot == WIN_LOG'(i))
					rbuf_ok[i] <= 1'b0;

	always_ff @(posedge clk)
		if (rx_valid && rx_in_win && rx_has_data && !rbuf_ok[rx_slot])
			rbuf_data[rx_slot] <= rx_data;

	// ==========================================================
	// two-entry output buffer toward the convergence layer
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			convergence_layer_valid <= 1'b0;
			convergence_layer_data <= '0;
			sp_valid <= 1'b0;
			sp_data <= '0;
		end
		else if (!convergence_layer_valid || convergence_layer_ready)
		begin
			if (sp_valid)
			begin
				convergence_layer_data <= sp_data;
				sp_valid <= 1'b0;
			end
			else
			begin
				convergence_layer_valid <= deliver;
				if (deliver)
					convergence_layer_data <= rbuf_data[exp_slot];
			end
		end
		else if (deliver)
		begin
			sp_valid <= 1'b1;
			sp_data <= rbuf_data[exp_slot];
		end

	// ==========================================================
	// acknowledgement generation
	logic [TICK_W-1:0] ack_tmr;
	logic ack_trig;
	assign ack_trig = (rx_valid && rx_flush)
		|| (ack_auto_en && tick && ack_tmr == '0);

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			ack_valid <= 1'b0;
			ack_packet_sequence_id <= '0;
			ack_nack_present <= 1'b0;
			ack_window <= '0;
			ack_tmr <= ACK_LOAD;
		end
		else
		begin
			if (ack_trig)
			begin
				ack_valid <= 1'b1;
				ack_packet_sequence_id <= rx_exp;
				ack_nack_present <= top_off != '0;
				ack_window <= WIN_FULL - top_off[WIN_LOG:0];
				ack_tmr <= ACK_LOAD;
			end
			else
			begin
				if (ack_ready)
					ack_valid <= 1'b0;
				if (tick && ack_tmr != '0)
					ack_tmr <= ack_tmr - 1'b1;
			end
		end

	// ==========================================================
	// send window
	logic [ID_W-1:0] tx_base;
	logic [ID_W-1:0] tx_next;
	logic [ID_W-1:0] outstanding;
	logic [WIN_LOG:0] peer_win;
	logic new_pend;
	logic flush_req;
	logic flush_due;
	logic [TICK_W-1:0] flush_tmr;
	logic [WIN-1:0] in_use;
	logic [WIN-1:0] pend;
	logic [WIN-1:0] expire;
	logic [WIN-1:0] give_up;
	logic launch;
	logic pick_hit;
	logic [WIN_LOG-1:0] pick_slot;
	logic [ID_W-1:0] pick_id;
	logic send_new;
	logic send_retx;
	logic [ID_W-1:0] fb_limit;
	logic fb_apply;
	logic [ID_W-1:0] fb_span;
	logic nack_ok;

	assign outstanding = tx_next - tx_base;
	assign launch = !snd_valid || snd_ready;
	assign fb_limit = fb_nack_present ? fb_nack_id : fb_ack_id;
	assign fb_span = fb_limit - tx_base;
	assign fb_apply = fb_valid && (fb_nack_present || fb_ack_present)
		&& fb_span <= outstanding;
	assign nack_ok = nack_valid && (nack_id - tx_base) < outstanding;

	// oldest pending resend goes first
	always_comb
	begin
		pick_hit = 1'b0;
		pick_slot = '0;
		pick_id = '0;
		for (int k = WIN - 1; k >= 0; k--)
			if (pend[(tx_base[WIN_LOG-1:0] + WIN_LOG'(k))] && ID_W'(k) < outstanding)
			begin
				pick_hit = 1'b1;
				pick_slot = tx_base[WIN_LOG-1:0] + WIN_LOG'(k);
				pick_id = tx_base + ID_W'(k);
			end
	end

	assign send_retx = launch && pick_hit && !teardown;
	assign send_new = launch && !pick_hit && new_pend && !teardown
		&& outstanding < ID_W'(WIN) && peer_win != '0;

	genvar g;
	generate
		for (g = 0; g < WIN; g++)
		begin : g_entry
			logic [TICK_W-1:0] tmr;
			logic [RETRY_W-1:0] tries;
			logic [ID_W-1:0] rel;
			logic pend_q;
			assign pend[g] = pend_q;
			assign rel = ID_W'(WIN_LOG'(g) - tx_base[WIN_LOG-1:0]);
			assign in_use[g] = rel < outstanding;
			assign expire[g] = in_use[g] && tick && tmr == TICK_W'(1);
			assign give_up[g] = expire[g] && tries == RETRY_MAX;
			always_ff @(posedge clk or negedge nrst)
				if (!nrst)
				begin
					tmr <= '0;
					tries <= '0;
					pend_q <= 1'b0;
				end
				else if (send_new && tx_next[WIN_LOG-1:0] == WIN_LOG'(g))
				begin
					tmr <= RETX_LOAD;
					tries <= '0;
					pend_q <= 1'b0;
				end
				else if (fb_apply && rel < fb_span)
				begin
					tmr <= '0;
					pend_q <= 1'b0;
				end
				else
				begin
					// nack resends never touch the timer; timer reloads only itself
					if (expire[g])
					begin
						tmr <= RETX_LOAD;
						tries <= tries + 1'b1;
					end
					else if (tick && tmr > TICK_W'(1))
						tmr <= tmr - 1'b1;
					if (expire[g] || (nack_ok && nack_id[WIN_LOG-1:0] == WIN_LOG'(g)))
						pend_q <= 1'b1;
					else if (send_retx && pick_slot == WIN_LOG'(g))
						pend_q <= 1'b0;
				end
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			tx_base <= '0;
			tx_next <= '0;
			peer_win <= WIN_FULL;
		end
		else
		begin
			if (fb_apply)
				tx_base <= fb_limit;
			if (send_new)
				tx_next <= tx_next + 1'b1;
			if (fb_valid)
				peer_win <= fb_window;
			else if (send_new && peer_win != '0)
				peer_win <= peer_win - 1'b1;
		end

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			new_pend <= 1'b0;
			tx_new_ready <= 1'b0;
		end
		else
		begin
			if (tx_new_valid && tx_new_ready)
				new_pend <= 1'b1;
			else if (send_new)
				new_pend <= 1'b0;
			tx_new_ready <= !teardown && !(tx_new_valid && tx_new_ready)
				&& (!new_pend || send_new);
		end

	// flush timer runs on its own, so progress never waits on a spontaneous ack
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			flush_req <= 1'b0;
			flush_due <= 1'b0;
			flush_tmr <= FLUSH_LOAD;
		end
		else
		begin
			if (convergence_layer_flush_req)
				flush_req <= 1'b1;
			else if (send_new || send_retx)
				flush_req <= 1'b0;
			if (fb_valid || outstanding == '0)
			begin
				flush_tmr <= FLUSH_LOAD;
				flush_due <= 1'b0;
			end
			else if (tick && flush_tmr == TICK_W'(1))
			begin
				flush_tmr <= FLUSH_LOAD;
				flush_due <= 1'b1;
			end
			else
			begin
				if (tick && flush_tmr != '0)
					flush_tmr <= flush_tmr - 1'b1;
				if (send_new || send_retx)
					flush_due <= 1'b0;
			end
		end

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			snd_valid <= 1'b0;
			snd_packet_sequence_id <= '0;
			snd_retx <= 1'b0;
			snd_flush <= 1'b0;
			teardown <= 1'b0;
		end
		else
		begin
			if (|give_up)
				teardown <= 1'b1;
			if (send_retx || send_new)
			begin
				snd_valid <= 1'b1;
				snd_packet_sequence_id <= send_retx ? pick_id : tx_next;
				snd_retx <= send_retx;
				snd_flush <= flush_req || flush_due || peer_win <= (WIN_LOG+1)'(1)
					|| (send_new && outstanding == ID_W'(WIN - 1));
			end
			else if (snd_ready)
				snd_valid <= 1'b0;
		end
endmodule : mawe_engine

// ===== bench/mawe_chk.sv
// port checker for the window engine, bound to every engine instance
`timescale 1ns/1ps
module mawe_chk #(
	parameter int ID_W = 6,
	parameter int WIN_LOG = 3,
	parameter int DATA_W = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic rx_valid,
	input wire logic rx_flush,
	input wire logic ack_auto_en,
	input wire logic ack_valid,
	input wire logic ack_ready,
	input wire logic [WIN_LOG:0] ack_window,
	input wire logic convergence_layer_valid,
	input wire logic [DATA_W-1:0] convergence_layer_data,
	input wire logic convergence_layer_ready,
	input wire logic tx_new_valid,
	input wire logic tx_new_ready,
	input wire logic snd_valid,
	input wire logic [ID_W-1:0] snd_packet_sequence_id,
	input wire logic snd_ready,
	input wire logic teardown
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ====================
	// acknowledgements
	a_ack_on_flush: assert property (rx_valid && rx_flush |=> ack_valid)
		else $error("flush packet not acknowledged");
	a_ack_holds: assert property (ack_valid && !ack_ready |=> ack_valid)
		else $error("ack dropped before taken");
	a_ack_released: assert property (ack_valid && ack_ready && !(rx_valid && rx_flush)
		&& !ack_auto_en |=> !ack_valid)
		else $error("ack repeated without cause");
	a_window_max: assert property (ack_window <= (1 << WIN_LOG))
		else $error("advertised window too large");
	// ====================
	// delivery and sending
	a_cl_holds: assert property (convergence_layer_valid && !convergence_layer_ready
		|=> convergence_layer_valid && $stable(convergence_layer_data))
		else $error("delivered word changed while stalled");
	a_snd_holds: assert property (snd_valid && !snd_ready
		|=> snd_valid && $stable(snd_packet_sequence_id))
		else $error("send command changed while stalled");
	a_new_gap: assert property (tx_new_valid && tx_new_ready |=> !tx_new_ready)
		else $error("new packet taken twice");
	a_teardown_sticky: assert property (teardown |=> teardown)
		else $error("teardown cleared");
endmodule : mawe_chk

bind mawe_engine mawe_chk #(.ID_W(ID_W), .WIN_LOG(WIN_LOG), .DATA_W(DATA_W)) i_mawe_chk (
	.clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_flush(rx_flush),
	.ack_auto_en(ack_auto_en), .ack_valid(ack_valid), .ack_ready(ack_ready),
	.ack_window(ack_window), .convergence_layer_valid(convergence_layer_valid),
	.convergence_layer_data(convergence_layer_data),
	.convergence_layer_ready(convergence_layer_ready), .tx_new_valid(tx_new_valid),
	.tx_new_ready(tx_new_ready), .snd_valid(snd_valid),
	.snd_packet_sequence_id(snd_packet_sequence_id), .snd_ready(snd_ready),
	.teardown(teardown));

// ===== bench/mawe_peer.sv
// link-side peer model: takes send commands after a set stall and logs them
`timescale 1ns/1ps
module mawe_peer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] peer_stall,
	input wire logic snd_valid,
	input wire logic [mawe_pkg::ID_W-1:0] snd_packet_sequence_id,
	input wire logic snd_retx,
	input wire logic snd_flush,
	output logic snd_ready
);
	import mawe_pkg::*;
	logic [3:0] wait_cnt;
	logic [ID_W-1:0] got_id[$];
	logic got_retx[$];
	logic got_flush[$];
	// ====================
	// acceptance
	// ready is a register, so even a zero stall leaves one waiting cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wait_cnt <= '0;
			snd_ready <= 1'b0;
		end
		else if (snd_valid && snd_ready)
		begin
			got_id.push_back(snd_packet_sequence_id);
			got_retx.push_back(snd_retx);
			got_flush.push_back(snd_flush);
			snd_ready <= 1'b0;
			wait_cnt <= '0;
		end
		else if (snd_valid && wait_cnt >= peer_stall)
			snd_ready <= 1'b1;
		else if (snd_valid)
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule : mawe_peer

// ===== bench/mawe_engine_bench.sv
// self-checking bench: reordering, acks, send window, timers
`timescale 1ns/1ps
module mawe_engine_bench;
	import mawe_pkg::*;
	logic clk, nrst, rx_valid, rx_has_data, rx_flush, convergence_layer_ready, ack_auto_en;
	logic ack_ready, tx_new_valid, convergence_layer_flush_req, snd_ready, fb_valid;
	logic fb_nack_present, fb_ack_present, nack_valid, convergence_layer_valid, ack_valid;
	logic ack_nack_present, tx_new_ready, snd_valid, snd_retx, snd_flush, teardown;
	logic [ID_W-1:0] rx_packet_sequence_id, ack_packet_sequence_id, snd_packet_sequence_id;
	logic [ID_W-1:0] fb_nack_id, fb_ack_id, nack_id;
	logic [DATA_W-1:0] rx_data, convergence_layer_data;
	logic [WIN_LOG:0] ack_window, fb_window;
	logic [3:0] peer_stall;
	int err_total, checks_done, wd, ncmd;
	// short timers keep the run brief
	mawe_engine #(.TICK_CYC(8), .RETX_TICKS(12), .FLUSH_TICKS(6), .ACK_GAP_TICKS(4),
		.MAX_RETRIES(1)) i_mawe_engine (
		.clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_has_data(rx_has_data),
		.rx_flush(rx_flush), .rx_packet_sequence_id(rx_packet_sequence_id),
		.rx_data(rx_data), .convergence_layer_valid(convergence_layer_valid),
		.convergence_layer_data(convergence_layer_data),
		.convergence_layer_ready(convergence_layer_ready), .ack_auto_en(ack_auto_en),
		.ack_valid(ack_valid), .ack_packet_sequence_id(ack_packet_sequence_id),
		.ack_nack_present(ack_nack_present), .ack_window(ack_window), .ack_ready(ack_ready),
		.tx_new_valid(tx_new_valid), .tx_new_ready(tx_new_ready),
		.convergence_layer_flush_req(convergence_layer_flush_req), .snd_valid(snd_valid),
		.snd_packet_sequence_id(snd_packet_sequence_id), .snd_retx(snd_retx),
		.snd_flush(snd_flush), .snd_ready(snd_ready), .fb_valid(fb_valid),
		.fb_nack_present(fb_nack_present), .fb_nack_id(fb_nack_id),
		.fb_ack_present(fb_ack_present), .fb_ack_id(fb_ack_id), .fb_window(fb_window),
		.nack_valid(nack_valid), .nack_id(nack_id), .teardown(teardown));
	mawe_peer i_mawe_peer (.clk(clk), .nrst(nrst), .peer_stall(peer_stall),
		.snd_valid(snd_valid), .snd_packet_sequence_id(snd_packet_sequence_id),
		.snd_retx(snd_retx), .snd_flush(snd_flush), .snd_ready(snd_ready));
	// ====================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic tick;
		@(posedge clk);
		wd++;
		if (wd > 400)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask : tick
	task automatic rx(input logic [5:0] id, input logic dat, input logic fl, input logic [31:0] d);
		rx_valid <= 1'b1;
		rx_packet_sequence_id <= id;
		rx_has_data <= dat;
		rx_flush <= fl;
		rx_data <= d;
		@(posedge clk);
		rx_valid <= 1'b0;
		@(posedge clk);
	endtask : rx
	task automatic get_cl(input logic [31:0] d);
		wd = 0;
		while (convergence_layer_valid !== 1'b1)
			tick();
		chk(convergence_layer_data, d);
		convergence_layer_ready <= 1'b1;
		@(posedge clk);
		convergence_layer_ready <= 1'b0;
		@(posedge clk);
	endtask : get_cl
	task automatic get_ack(input logic [5:0] id, input logic nk, input logic [3:0] w);
		wd = 0;
		while (ack_valid !== 1'b1)
			tick();
		chk(ack_packet_sequence_id, id);
		chk(ack_nack_present, nk);
		chk(ack_window, w);
		ack_ready <= 1'b1;
		@(posedge clk);
		ack_ready <= 1'b0;
		@(posedge clk);
	endtask : get_ack
	task automatic offer;
		wd = 0;
		tx_new_valid <= 1'b1;
		do
			tick();
		while (tx_new_ready !== 1'b1);
		tx_new_valid <= 1'b0;
		@(posedge clk);
	endtask : offer
	// fl of x leaves the flush bit unchecked
	task automatic cmd(input logic [5:0] id, input logic rt, input logic fl);
		wd = 0;
		while (i_mawe_peer.got_id.size() <= ncmd)
			tick();
		chk(i_mawe_peer.got_id[ncmd], id);
		chk(i_mawe_peer.got_retx[ncmd], rt);
		if (fl !== 1'bx)
			chk(i_mawe_peer.got_flush[ncmd], fl);
		ncmd++;
	endtask : cmd
	task automatic fb(input logic np, input logic [5:0] nid, input logic [5:0] aid);
		fb_valid <= 1'b1;
		fb_nack_present <= np;
		fb_nack_id <= nid;
		fb_ack_present <= !np;
		fb_ack_id <= aid;
		fb_window <= 4'h8;
		nack_valid <= np;
		nack_id <= nid;
		@(posedge clk);
		fb_valid <= 1'b0;
		nack_valid <= 1'b0;
		@(posedge clk);
	endtask : fb
	// ====================
	// scenarios
	task automatic s_reorder;
		rx(6'h00, 1'b0, 1'b0, 32'h0);
		rx(6'h02, 1'b1, 1'b0, 32'hb2);
		rx(6'h29, 1'b1, 1'b1, 32'hee);
		get_ack(6'h01, 1'b1, 4'h6);
		chk(convergence_layer_valid, 1'b0);
		rx(6'h01, 1'b1, 1'b0, 32'ha1);
		get_cl(32'ha1);
		get_cl(32'hb2);
		rx(6'h1e, 1'b1, 1'b1, 32'hee);
		get_ack(6'h03, 1'b0, 4'h8);
		chk(convergence_layer_valid, 1'b0);
	endtask : s_reorder
	task automatic s_auto;
		ack_auto_en <= 1'b1;
		get_ack(6'h03, 1'b0, 4'h8);
		ack_auto_en <= 1'b0;
	endtask : s_auto
	task automatic s_send;
		peer_stall <= 4'h1;
		for (int i = 0; i < 8; i++)
			offer();
		cmd(6'h00, 1'b0, 1'b0);
		for (int i = 1; i < 7; i++)
			cmd(6'(i), 1'b0, 1'bx);
		cmd(6'h07, 1'b0, 1'b1);
		fb(1'b0, 6'h00, 6'h04);
		convergence_layer_flush_req <= 1'b1;
		@(posedge clk);
		convergence_layer_flush_req <= 1'b0;
		offer();
		cmd(6'h08, 1'b0, 1'b1);
		fb(1'b1, 6'h05, 6'h00);
		// nack resend carries no flush cause; the timer resend comes after the flush timeout
		cmd(6'h05, 1'b1, 1'b0);
		cmd(6'h05, 1'b1, 1'b1);
		wd = 0;
		while (teardown !== 1'b1)
			tick();
		chk(teardown, 1'b1);
	endtask : s_send
	// ====================
	// clock, reset and main sequence
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		{nrst, rx_valid, rx_has_data, rx_flush, convergence_layer_ready, ack_auto_en} = '0;
		{ack_ready, tx_new_valid, convergence_layer_flush_req, fb_valid, fb_nack_present} = '0;
		{fb_ack_present, nack_valid, rx_packet_sequence_id, fb_nack_id, fb_ack_id} = '0;
		{nack_id, rx_data, fb_window, peer_stall, err_total, checks_done, wd, ncmd} = '0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		s_reorder();
		s_auto();
		s_send();
		tally_and_finish();
	end
endmodule : mawe_engine_bench
